// >>> pkg/hbridge_fault_control_pkg.sv
// constants and types shared by the h-bridge fault control block
package hbridge_fault_control_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  // stall window, well beyond the slowest legal pwm period
  localparam int STALL_TIME_NS = 10000;
  // least time, so round up
  localparam int STALL_CYCLES = (STALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STALL_CNT_W = 16;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h0c;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h10;

  // control fields
  localparam int CTRL_MUTE_BIT = 0;
  localparam logic CONTROL_RESET = 1'b0;

  // status fields
  localparam int ST_SHUTDOWN_N_BIT = 0;
  localparam int ST_CODE_LSB = 1;
  localparam int ST_SHORT_BIT = 3;
  localparam int ST_OVERTEMP_BIT = 4;
  localparam int ST_WARN_BIT = 5;
  localparam int ST_LOWREG_BIT = 6;
  localparam int ST_ILLEGAL_BIT = 7;
  localparam int ST_STALL_BIT = 8;
  localparam int ST_RESET_BIT = 9;
  localparam int ST_PDOWN_BIT = 10;

  // interrupt event bits
  localparam int EV_W = 5;
  localparam int EV_SHORT = 0;
  localparam int EV_OVERTEMP = 1;
  localparam int EV_LOWREG = 2;
  localparam int EV_ILLEGAL = 3;
  localparam int EV_WARN = 4;
  localparam logic [EV_W-1:0] EV_RESET = 5'h00;

  // ************************************************************
  // fault codes on the two code pins (bit1, bit0)
  // ************************************************************
  localparam logic [1:0] CODE_ILLEGAL = 2'h0;
  localparam logic [1:0] CODE_SHORT = 2'h1;
  localparam logic [1:0] CODE_OVERTEMP = 2'h2;
  localparam logic [1:0] CODE_WARN = 2'h2;
  localparam logic [1:0] CODE_LOWREG = 2'h3;
  localparam logic [1:0] CODE_NORMAL = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_POWER_DOWN,
    MODE_RESET,
    MODE_SHORT,
    MODE_FAULT,
    MODE_RUN
  } mode_t;

endpackage

// >>> hdl/hbridge_fault_control.sv
// h-bridge pwm decode, fault supervision and axi4-lite status registers
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps

module hbridge_fault_control #(
  parameter int stall_cycles = hbridge_fault_control_pkg::STALL_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  // device pins
  input wire logic power_down_n,
  input wire logic bridge_reset_n,
  input wire logic half_a_pos_in,
  input wire logic half_a_neg_in,
  input wire logic half_b_pos_in,
  input wire logic half_b_neg_in,
  // analog sense comparators
  input wire logic short_circuit_det,
  input wire logic temp_warn_det,
  input wire logic temp_shut_det,
  input wire logic gate_reg_out_a_low,
  input wire logic gate_reg_out_b_low,
  // bridge commands, oe low means high impedance
  output logic bridge_out_a,
  output logic bridge_out_a_oe,
  output logic bridge_out_b,
  output logic bridge_out_b_oe,
  // open-drain pins: value is always low, oe high pulls the pin low; irq is a plain driven output
  output logic shutdown_n_o,
  output logic shutdown_n_oe,
  output logic fault_code_bit0_n_o,
  output logic fault_code_bit0_n_oe,
  output logic fault_code_bit1_n_o,
  output logic fault_code_bit1_n_oe,
  output logic irq,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SYNC_W = 11;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;

  // all pins are asynchronous to core_clk
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {power_down_n, bridge_reset_n, half_a_pos_in, half_a_neg_in,
                    half_b_pos_in, half_b_neg_in, short_circuit_det, temp_warn_det,
                    temp_shut_det, gate_reg_out_a_low, gate_reg_out_b_low};
      sync2_reg <= sync1_reg;
    end
  end

  logic pdown_n_s, breset_n_s, a_pos_s, a_neg_s, b_pos_s, b_neg_s;
  logic short_s, warn_s, shut_s, reg_a_low_s, reg_b_low_s;
  assign {pdown_n_s, breset_n_s, a_pos_s, a_neg_s, b_pos_s, b_neg_s, short_s, warn_s,
          shut_s, reg_a_low_s, reg_b_low_s} = sync2_reg;

  // ************************************************************
  // software control
  // ************************************************************
  logic mute_reg;
  logic in_reset;
  logic powered;

  // software mute acts as an extra reset request, so it also clears faults
  assign in_reset = !breset_n_s || mute_reg;
  assign powered = pdown_n_s;

  // ************************************************************
  // activity detector
  // ************************************************************
  logic [3:0] pwm_last_reg;
  logic [hbridge_fault_control_pkg::STALL_CNT_W-1:0] stall_cnt_reg;
  logic stalled;

  // restarts on any edge of any pwm input; saturates at the window
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwm_last_reg <= '0;
      stall_cnt_reg <= '0;
    end
    else
    begin
      pwm_last_reg <= {a_pos_s, a_neg_s, b_pos_s, b_neg_s};
      if (!powered || in_reset || pwm_last_reg != {a_pos_s, a_neg_s, b_pos_s, b_neg_s})
        stall_cnt_reg <= '0; // inputs ignored in reset
      else if (!stalled)
        stall_cnt_reg <= stall_cnt_reg + 1'b1;
    end
  end

  assign stalled = 32'(stall_cnt_reg) >= stall_cycles;

  // ************************************************************
  // fault state
  // ************************************************************
  logic short_latch_reg;
  logic overtemp_reg;
  logic illegal;
  logic lowreg;

  // equal patterns on a pair are illegal
  assign illegal = (a_pos_s == a_neg_s) || (b_pos_s == b_neg_s) || stalled;
  assign lowreg = reg_a_low_s || reg_b_low_s;

  // short latch holds until reset while powered; that reset also clears overtemp but leaves the sticky irq bits set
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      short_latch_reg <= 1'b0;
    else if (powered && in_reset)
      short_latch_reg <= 1'b0;
    else if (powered && short_s)
      short_latch_reg <= 1'b1;
  end

  // hysteresis: set above shutdown threshold, clear once below warning level
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      overtemp_reg <= 1'b0;
    else if (!powered || in_reset)
      overtemp_reg <= 1'b0;
    else if (shut_s)
      overtemp_reg <= 1'b1;
    else if (!warn_s)
      overtemp_reg <= 1'b0; // non-latching
  end

  // ************************************************************
  // mode and pin decode
  // ************************************************************
  hbridge_fault_control_pkg::mode_t mode;
  logic [1:0] code;

  // power-down beats reset, reset beats the short latch
  always_comb
  begin
    code = hbridge_fault_control_pkg::CODE_NORMAL;
    if (!powered)
      mode = hbridge_fault_control_pkg::MODE_POWER_DOWN;
    else if (in_reset)
      mode = hbridge_fault_control_pkg::MODE_RESET;
    else if (short_latch_reg)
    begin
      mode = hbridge_fault_control_pkg::MODE_SHORT;
      code = hbridge_fault_control_pkg::CODE_SHORT;
    end
    else if (lowreg)
    begin
      mode = hbridge_fault_control_pkg::MODE_FAULT;
      code = hbridge_fault_control_pkg::CODE_LOWREG;
    end
    else if (overtemp_reg)
    begin
      mode = hbridge_fault_control_pkg::MODE_FAULT;
      code = hbridge_fault_control_pkg::CODE_OVERTEMP;
    end
    else if (illegal)
    begin
      mode = hbridge_fault_control_pkg::MODE_FAULT;
      code = hbridge_fault_control_pkg::CODE_ILLEGAL;
    end
    else
    begin
      mode = hbridge_fault_control_pkg::MODE_RUN;
      if (warn_s)
        code = hbridge_fault_control_pkg::CODE_WARN;
    end
  end

  // pins registered so each bridge and oe output comes from a flip-flop
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bridge_out_a <= 1'b0;
      bridge_out_a_oe <= 1'b0;
      bridge_out_b <= 1'b0;
      bridge_out_b_oe <= 1'b0;
      shutdown_n_oe <= 1'b0;
      fault_code_bit0_n_oe <= 1'b0;
      fault_code_bit1_n_oe <= 1'b0;
    end
    else
    begin
      case (mode)
        hbridge_fault_control_pkg::MODE_POWER_DOWN:
        begin
          bridge_out_a_oe <= 1'b0;
          bridge_out_b_oe <= 1'b0;
        end
        hbridge_fault_control_pkg::MODE_SHORT:
        begin
          bridge_out_a_oe <= 1'b0;
          bridge_out_b_oe <= 1'b0;
        end
        hbridge_fault_control_pkg::MODE_RUN:
        begin
          bridge_out_a_oe <= 1'b1;
          bridge_out_b_oe <= 1'b1;
        end
        default:
        begin
          bridge_out_a_oe <= 1'b1; // low-low
          bridge_out_b_oe <= 1'b1;
        end
      endcase
      bridge_out_a <= (mode == hbridge_fault_control_pkg::MODE_RUN) && a_pos_s;
      bridge_out_b <= (mode == hbridge_fault_control_pkg::MODE_RUN) && b_pos_s;
      // open drain: pull low only for a zero, release in power-down
      shutdown_n_oe <= (mode == hbridge_fault_control_pkg::MODE_SHORT) ||
                       (mode == hbridge_fault_control_pkg::MODE_FAULT);
      fault_code_bit0_n_oe <= powered && !code[0];
      fault_code_bit1_n_oe <= powered && !code[1];
    end
  end

  // open-drain drivers only ever pull low
  assign shutdown_n_o = 1'b0;
  assign fault_code_bit0_n_o = 1'b0;
  assign fault_code_bit1_n_o = 1'b0;

  // ************************************************************
  // interrupt events
  // ************************************************************
  logic [hbridge_fault_control_pkg::EV_W-1:0] ev_level;
  logic [hbridge_fault_control_pkg::EV_W-1:0] ev_last_reg;
  logic [hbridge_fault_control_pkg::EV_W-1:0] irq_status_reg;
  logic [hbridge_fault_control_pkg::EV_W-1:0] irq_enable_reg;
  logic [hbridge_fault_control_pkg::EV_W-1:0] irq_clear;

  assign ev_level = {powered && !in_reset && warn_s,
                     mode == hbridge_fault_control_pkg::MODE_FAULT && code ==
                       hbridge_fault_control_pkg::CODE_ILLEGAL,
                     powered && !in_reset && lowreg,
                     overtemp_reg,
                     short_latch_reg};

  // rising edges set sticky bits; a set in the clear cycle wins
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ev_last_reg <= hbridge_fault_control_pkg::EV_RESET;
      irq_status_reg <= hbridge_fault_control_pkg::EV_RESET;
      irq <= 1'b0;
    end
    else
    begin
      ev_last_reg <= ev_level;
      irq_status_reg <= (irq_status_reg & ~irq_clear) | (ev_level & ~ev_last_reg);
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  logic wr_take;
  logic wr_hit;
  logic [7:0] wr_ofs;

  // address and data are taken together in one cycle, one write at a time
  assign wr_take = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign wr_ofs = s_axi_awaddr & 8'hfc;
  assign wr_hit = wr_ofs == hbridge_fault_control_pkg::CONTROL_OFS ||
                  wr_ofs == hbridge_fault_control_pkg::IRQ_CLEAR_OFS ||
                  wr_ofs == hbridge_fault_control_pkg::IRQ_ENABLE_OFS;
  assign irq_clear = (wr_take && s_axi_wstrb[0] &&
                      wr_ofs == hbridge_fault_control_pkg::IRQ_CLEAR_OFS) ?
                     s_axi_wdata[hbridge_fault_control_pkg::EV_W-1:0] : '0;

  // write channel handshake and response
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= hbridge_fault_control_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      s_axi_wready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? hbridge_fault_control_pkg::RESP_OKAY :
                                hbridge_fault_control_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // writable registers, low byte lane only
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mute_reg <= hbridge_fault_control_pkg::CONTROL_RESET;
      irq_enable_reg <= hbridge_fault_control_pkg::EV_RESET;
    end
    else if (wr_take && s_axi_wstrb[0])
    begin
      if (wr_ofs == hbridge_fault_control_pkg::CONTROL_OFS)
        mute_reg <= s_axi_wdata[hbridge_fault_control_pkg::CTRL_MUTE_BIT];
      if (wr_ofs == hbridge_fault_control_pkg::IRQ_ENABLE_OFS)
        irq_enable_reg <= s_axi_wdata[hbridge_fault_control_pkg::EV_W-1:0];
    end
  end

  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [7:0] rd_ofs;

  // live state as seen on the pins
  always_comb
  begin
    status_word = '0;
    status_word[hbridge_fault_control_pkg::ST_SHUTDOWN_N_BIT] = !shutdown_n_oe;
    status_word[hbridge_fault_control_pkg::ST_CODE_LSB +: 2] =
      {!fault_code_bit1_n_oe, !fault_code_bit0_n_oe};
    status_word[hbridge_fault_control_pkg::ST_SHORT_BIT] = short_latch_reg;
    status_word[hbridge_fault_control_pkg::ST_OVERTEMP_BIT] = overtemp_reg;
    status_word[hbridge_fault_control_pkg::ST_WARN_BIT] = warn_s;
    status_word[hbridge_fault_control_pkg::ST_LOWREG_BIT] = lowreg;
    status_word[hbridge_fault_control_pkg::ST_ILLEGAL_BIT] = illegal;
    status_word[hbridge_fault_control_pkg::ST_STALL_BIT] = stalled;
    status_word[hbridge_fault_control_pkg::ST_RESET_BIT] = in_reset;
    status_word[hbridge_fault_control_pkg::ST_PDOWN_BIT] = !powered;
  end

  // read decode; the clear register reads as zero
  always_comb
  begin
    rd_ofs = s_axi_araddr & 8'hfc;
    rd_hit = 1'b1;
    rd_word = '0;
    case (rd_ofs)
      hbridge_fault_control_pkg::STATUS_OFS: rd_word = status_word;
      hbridge_fault_control_pkg::CONTROL_OFS: rd_word = {31'h0, mute_reg};
      hbridge_fault_control_pkg::IRQ_STATUS_OFS: rd_word = {27'h0, irq_status_reg};
      hbridge_fault_control_pkg::IRQ_CLEAR_OFS: rd_word = '0;
      hbridge_fault_control_pkg::IRQ_ENABLE_OFS: rd_word = {27'h0, irq_enable_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: one read at a time, data captured at the address edge
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= hbridge_fault_control_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? hbridge_fault_control_pkg::RESP_OKAY :
                                hbridge_fault_control_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // hbridge_fault_control

// >>> sim/pwm_source_model.sv
// modulator-side model: pwm pairs and device reset request
`timescale 1ns/100ps

module pwm_source_model (
  input wire logic core_clk,
  input wire logic run,
  input wire logic [3:0] pat,
  input wire logic rst_req_n,
  output logic half_a_pos_in,
  output logic half_a_neg_in,
  output logic half_b_pos_in,
  output logic half_b_neg_in,
  output logic bridge_reset_n
);
  // ********
  // pwm drive
  // ********
  logic [1:0] ph_cnt = 2'h0;
  logic ph = 1'b0;
  logic [3:0] pins = 4'h6;
  logic rst_q = 1'b0;
  assign {half_a_pos_in, half_a_neg_in, half_b_pos_in, half_b_neg_in} = pins;
  assign bridge_reset_n = rst_q;
  // half period of four cycles, well inside the stall window
  always_ff @(posedge core_clk)
  begin
    ph_cnt <= ph_cnt + 2'h1;
    if (ph_cnt == 2'h3)
      ph <= !ph;
  end
  // complementary pairs while running, else a held or broken pattern
  always_ff @(posedge core_clk)
  begin
    pins <= run ? {ph, !ph, !ph, ph} : pat;
  end
  // bench decides how long reset stays low
  always_ff @(posedge core_clk)
  begin
    rst_q <= rst_req_n;
  end
endmodule // pwm_source_model

// >>> sim/hbridge_fault_control_checker.sv
// pin-level assertions for the h-bridge fault control block
`timescale 1ns/100ps

module hbridge_fault_control_checker #(
  parameter int stall_cycles = hbridge_fault_control_pkg::STALL_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic power_down_n,
  input wire logic bridge_reset_n,
  input wire logic half_a_pos_in,
  input wire logic half_a_neg_in,
  input wire logic half_b_pos_in,
  input wire logic half_b_neg_in,
  input wire logic short_circuit_det,
  input wire logic temp_warn_det,
  input wire logic temp_shut_det,
  input wire logic gate_reg_out_a_low,
  input wire logic gate_reg_out_b_low,
  input wire logic bridge_out_a,
  input wire logic bridge_out_a_oe,
  input wire logic bridge_out_b,
  input wire logic bridge_out_b_oe,
  input wire logic shutdown_n_o,
  input wire logic shutdown_n_oe,
  input wire logic fault_code_bit0_n_o,
  input wire logic fault_code_bit0_n_oe,
  input wire logic fault_code_bit1_n_o,
  input wire logic fault_code_bit1_n_oe
);
  // ********
  // helpers
  // ********
  wire [3:0] pins = {half_a_pos_in, half_a_neg_in, half_b_pos_in, half_b_neg_in};
  wire live = power_down_n && bridge_reset_n && !short_circuit_det;
  wire quiet = !(temp_warn_det || temp_shut_det || gate_reg_out_a_low || gate_reg_out_b_low);
  wire drv_low = bridge_out_a_oe && !bridge_out_a && bridge_out_b_oe && !bridge_out_b;
  wire short_st = shutdown_n_oe && fault_code_bit1_n_oe && !fault_code_bit0_n_oe
    && !bridge_out_a_oe && !bridge_out_b_oe;
  logic [15:0] idle_reg;
  logic [3:0] pins_reg;
  // raw edges, so this leads the synced counter by a few cycles
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_reg <= 16'h0000;
      pins_reg <= 4'h0;
    end
    else
    begin
      pins_reg <= pins;
      if (!live || pins != pins_reg)
        idle_reg <= 16'h0000;
      else if (idle_reg != 16'hffff)
        idle_reg <= idle_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // margins of a few cycles cover the synchroniser lag
  a_pdown_release: assert property (!power_down_n [*4] |-> ##3
    !(bridge_out_a_oe || bridge_out_b_oe || shutdown_n_oe || fault_code_bit0_n_oe
    || fault_code_bit1_n_oe)) else $error("power-down left an output driven");
  a_reset_low: assert property ((power_down_n && !bridge_reset_n) [*4] |-> ##3
    drv_low && !shutdown_n_oe && !fault_code_bit1_n_oe && !fault_code_bit0_n_oe)
    else $error("reset state wrong");
  a_drain_only: assert property (1'b1 |->
    !(shutdown_n_o || fault_code_bit0_n_o || fault_code_bit1_n_o))
    else $error("open-drain pin driven high");
  a_short_entry: assert property (
    (power_down_n && bridge_reset_n && short_circuit_det) [*5] |-> ##3 short_st)
    else $error("short circuit not latched");
  a_short_hold: assert property (
    (power_down_n && bridge_reset_n) [*4] ##0 short_st |=> short_st)
    else $error("short latch lost without reset");
  a_lowreg_code: assert property (
    (live && (gate_reg_out_a_low || gate_reg_out_b_low)) [*5] ##0 !short_st |-> ##3
    drv_low && shutdown_n_oe && !fault_code_bit1_n_oe && !fault_code_bit0_n_oe)
    else $error("low regulator code wrong");
  a_overtemp_code: assert property (
    (live && temp_shut_det && !gate_reg_out_a_low && !gate_reg_out_b_low) [*5]
    ##0 !short_st |-> ##3 drv_low && shutdown_n_oe && !fault_code_bit1_n_oe
    && fault_code_bit0_n_oe) else $error("overtemp code wrong");
  a_stall_code: assert property (
    (int'(idle_reg) >= stall_cycles + 8 && quiet) [*5] ##0 !short_st |->
    drv_low && shutdown_n_oe && fault_code_bit1_n_oe && fault_code_bit0_n_oe)
    else $error("stalled input not flagged");
  a_pair_decode: assert property (
    (live && quiet && pins[3] != pins[2] && pins[1] != pins[0] && $stable(pins)
    && int'(idle_reg) < stall_cycles - 10) [*4] ##0 !short_st |-> ##3
    bridge_out_a_oe && bridge_out_a == $past(half_a_pos_in, 3) && bridge_out_b_oe
    && bridge_out_b == $past(half_b_pos_in, 3) && !shutdown_n_oe)
    else $error("pair decode wrong");
endmodule // hbridge_fault_control_checker

bind hbridge_fault_control hbridge_fault_control_checker #(.stall_cycles(stall_cycles)) chk (.*);

// >>> sim/hbridge_fault_control_test.sv
// self-checking bench for the h-bridge fault control block
`timescale 1ns/100ps

module hbridge_fault_control_test;
  // ********
  // stimulus
  // ********
  localparam int stall_n = 20;
  typedef struct packed {
    logic [3:0] pat;
    logic [3:0] sen;
    logic [6:0] exp;
  } row_t;
  // pattern, senses {shut, warn, reg a, reg b}, {oe a, a, oe b, b, pin levels}
  // neighbouring rows differ in pattern, so the stall window never runs out here
  localparam row_t rows [12] = '{
    '{4'h9, 4'h0, 7'h77}, '{4'h6, 4'h0, 7'h5f}, '{4'h2, 4'h0, 7'h50}, '{4'hd, 4'h0, 7'h50},
    '{4'h9, 4'h4, 7'h76}, '{4'h6, 4'h2, 7'h53}, '{4'h9, 4'h1, 7'h53}, '{4'h6, 4'hc, 7'h52},
    '{4'h9, 4'h4, 7'h52}, '{4'h6, 4'h0, 7'h5f}, '{4'h9, 4'ha, 7'h53}, '{4'h6, 4'h0, 7'h5f}};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_down_n = 1'b0;
  logic run = 1'b0;
  logic [3:0] pat = 4'h6;
  logic rst_req_n = 1'b0;
  logic short_circuit_det = 1'b0, temp_warn_det = 1'b0, temp_shut_det = 1'b0;
  logic gate_reg_out_a_low = 1'b0, gate_reg_out_b_low = 1'b0;
  logic half_a_pos_in, half_a_neg_in, half_b_pos_in, half_b_neg_in, bridge_reset_n;
  logic bridge_out_a, bridge_out_a_oe, bridge_out_b, bridge_out_b_oe, irq;
  logic shutdown_n_o, shutdown_n_oe, fault_code_bit0_n_o, fault_code_bit0_n_oe;
  logic fault_code_bit1_n_o, fault_code_bit1_n_oe;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  int miscompares = 0;
  int checked = 0;
  // pull-ups give the pin level; bridge value masked while high impedance
  wire [6:0] st = {bridge_out_a_oe, bridge_out_a & bridge_out_a_oe, bridge_out_b_oe,
    bridge_out_b & bridge_out_b_oe, shutdown_n_oe ? shutdown_n_o : 1'b1,
    fault_code_bit1_n_oe ? fault_code_bit1_n_o : 1'b1,
    fault_code_bit0_n_oe ? fault_code_bit0_n_o : 1'b1};

  hbridge_fault_control #(.stall_cycles(stall_n)) dut (.*);
  pwm_source_model partner (.*);

  initial
  begin
    forever #4 core_clk = !core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic check_pins(input logic [6:0] e);
    checked++;
    if (st !== e)
    begin
      miscompares++;
      $display("ERROR %0t pins %h expected %h", $time, st, e);
    end
  endtask

  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    cyc(20000);
    miscompares++;
    end_sim();
  end

  initial
  begin
    cyc(6);
    reset_n <= 1'b1;
    cyc(4);
    power_down_n <= 1'b1;
    cyc(20);
    check_pins(7'h57);
    rst_req_n <= 1'b1;
    foreach (rows[i])
    begin
      pat <= rows[i].pat;
      {temp_shut_det, temp_warn_det, gate_reg_out_a_low, gate_reg_out_b_low} <= rows[i].sen;
      cyc(9);
      check_pins(rows[i].exp);
    end
    $display("table done");
    pat <= 4'h9;
    cyc(stall_n + 20);
    check_pins(7'h50);
    run <= 1'b1;
    cyc(60);
    check_word({29'h0, st[2:0]}, 32'h7);
    $display("stall done");
    axi_rd(hbridge_fault_control_pkg::IRQ_STATUS_OFS);
    check_word(rd, 32'h1e);
    axi_wr(hbridge_fault_control_pkg::IRQ_CLEAR_OFS, 32'h1f);
    check_word({30'h0, resp}, 32'h0);
    axi_rd(hbridge_fault_control_pkg::IRQ_STATUS_OFS);
    check_word(rd, 32'h0);
    axi_wr(hbridge_fault_control_pkg::IRQ_ENABLE_OFS, 32'h1);
    check_word({31'h0, irq}, 32'h0);
    short_circuit_det <= 1'b1;
    cyc(6);
    short_circuit_det <= 1'b0;
    cyc(20);
    check_pins(7'h01);
    check_word({31'h0, irq}, 32'h1);
    axi_rd(hbridge_fault_control_pkg::STATUS_OFS);
    check_word(rd & 32'hf, 32'ha);
    axi_wr(hbridge_fault_control_pkg::IRQ_ENABLE_OFS, 32'h0);
    cyc(3);
    check_word({31'h0, irq}, 32'h0);
    axi_wr(hbridge_fault_control_pkg::IRQ_ENABLE_OFS, 32'h1);
    cyc(3);
    check_word({31'h0, irq}, 32'h1);
    axi_wr(hbridge_fault_control_pkg::IRQ_CLEAR_OFS, 32'h1);
    cyc(3);
    check_word({31'h0, irq}, 32'h0);
    $display("irq done");
    power_down_n <= 1'b0;
    cyc(8);
    check_pins(7'h07);
    rst_req_n <= 1'b0;
    cyc(8);
    check_pins(7'h07);
    power_down_n <= 1'b1;
    cyc(8);
    check_pins(7'h57);
    rst_req_n <= 1'b1;
    cyc(10);
    check_word({29'h0, st[2:0]}, 32'h7);
    axi_rd(8'h40);
    check_word({30'h0, resp}, {30'h0, hbridge_fault_control_pkg::RESP_SLVERR});
    check_word(rd, 32'h0);
    axi_wr(8'h40, 32'h1);
    check_word({30'h0, resp}, {30'h0, hbridge_fault_control_pkg::RESP_SLVERR});
    // low lane strobe off: the write is answered but must not land
    s_axi_wstrb <= 4'he;
    axi_wr(hbridge_fault_control_pkg::CONTROL_OFS, 32'h1);
    s_axi_wstrb <= 4'hf;
    axi_rd(hbridge_fault_control_pkg::CONTROL_OFS);
    check_word(rd, 32'h0);
    // software mute behaves like the reset pin while pwm keeps toggling
    axi_wr(hbridge_fault_control_pkg::CONTROL_OFS, 32'h1);
    cyc(4);
    check_pins(7'h57);
    axi_wr(hbridge_fault_control_pkg::CONTROL_OFS, 32'h0);
    cyc(6);
    check_word({29'h0, st[2:0]}, 32'h7);
    reset_n <= 1'b0;
    cyc(2);
    check_pins(7'h07);
    reset_n <= 1'b1;
    // synchronisers restart at zero, so power-down shows first
    cyc(2);
    check_pins(7'h07);
    cyc(10);
    check_word({27'h0, st[6], st[4], st[2:0]}, 32'h1f);
    $display("reset done");
    end_sim();
  end
endmodule // hbridge_fault_control_test
